/* verilog/qflag_defines.svh */
// Offsets, field positions and timing counts for the queue flag block
`ifndef QFLAG_DEFINES_SVH
`define QFLAG_DEFINES_SVH
`define AE_OFFSET_LOW 8'h08
`define AE_OFFSET_HIGH 8'h80
`define END_MARK_BIT 35
`define START_MARK_BIT 34
`define RD_ASSERT_DLY 2
`define WR_RELEASE_DLY 1
`define PR_SET_DLY 2
`define PR_CLR_DLY 2
`define CHIP_FIELD_LSB 2
`endif

/* verilog/qflag_pkg.sv */
// Types shared by the queue flag block
package qflag_pkg;
	typedef enum logic [1:0] {
		IN_X36 = 2'h0,
		IN_X18 = 2'h1,
		IN_X9 = 2'h2
	} in_width_type;
	typedef enum logic [1:0] {
		OUT_X36 = 2'h0,
		OUT_X18 = 2'h1,
		OUT_X9 = 2'h2
	} out_width_type;
	typedef struct packed {
		logic flag_mode;
		logic packet_mode;
		logic offset_sel;
		logic leader;
	} strap_type;
	typedef enum logic [1:0] {
		AF_IDLE = 2'b00,
		AF_SYNC = 2'b01,
		AF_OWN = 2'b11
	} af_state_type;
endpackage

/* verilog/queue_flag_status.sv */
// Queue flag status, flag bus and almost-full bus expansion logic
// Operation
// - Default almost-empty offset is 8 with strap low, 128 with strap high.
// - Active almost-empty flag goes low two clocks after boundary read.
// - Active almost-empty flag goes high one clock after boundary write.
// - x36 to x36: bus bit high after offset+2 or offset+1 writes.
// - x36 to narrower output: bus bit high after offset+1 writes.
// - x18 input to x36 output: bus bit high after twice offset+2 or offset+1 writes.
// - x9 input to x36 output: bus bit high after four times offset+2 or offset+1 writes.
// - Bus bit low two clocks after read, high one clock after write.
// - A read queue switch may add one clock to a bus bit.
// - Packet-ready flag and bus change only on clock edges.
// - Packet-ready flag goes low on end marker after a start marker.
// - Packet-ready flag goes low two clocks after end-marker write.
// - Packet-ready flag goes high when last start marker is read.
// - Packet-ready flag goes high two clocks after that read.
// - Packet-ready bus bits follow the active flag, maybe one clock later.
// - Direct mode: matching chip number with strobe takes almost-full bus.
// - Almost-full bus shows newly selected device one clock later.
// - Polled mode: leader drives bus and sync pulse first edge after reset.
// - Token passes onward; next device owns bus the following clock.
// - Token output high exactly in the cycle the device owns the bus.
// - Packet strap selects packet-ready or almost-empty on the flag bus.
// - Only one device drives the shared flag bus at a time.
//
// Chosen here: the address map and strobed register access.
`timescale 1ns/1ps
`include "qflag_defines.svh"
module queue_flag_status
	import qflag_pkg::*;
#(
	parameter int QUEUES = 4,
	parameter int LVL_W = 16,
	parameter int QA_W = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Mode straps; flag, packet, offset and leader straps are sampled while master reset is low, chip number and widths are not
	input wire logic master_reset_n,
	input wire logic default_offset_sel,
	input wire logic packet_mode_sel,
	input wire logic flag_mode_sel,
	input wire logic chain_leader_sel,
	input wire logic [2:0] chip_number_pins,
	input wire in_width_type in_width,
	input wire out_width_type out_width,
	// Write side
	input wire logic wr_en,
	input wire logic [QA_W-1:0] wr_queue,
	input wire logic [35:0] wr_data,
	input wire logic [4:0] write_queue_addr,
	input wire logic af_bus_strobe,
	input wire logic [QUEUES-1:0] af_status_in,
	input wire logic af_token_in,
	// Read side
	input wire logic rd_en,
	input wire logic [QA_W-1:0] rd_queue,
	input wire logic rd_switch,
	input wire logic [35:0] rd_data,
	input wire logic flag_bus_grant,
	// Flags
	output logic almost_empty_flag,
	output logic packet_ready_flag,
	output logic [QUEUES-1:0] ae_status_bus,
	output logic [QUEUES-1:0] ae_status_bus_oe,
	output logic [QUEUES-1:0] af_status_bus,
	output logic [QUEUES-1:0] af_status_bus_oe,
	output logic af_sync_pulse,
	output logic af_token_out
);
	localparam int CW = LVL_W + 2;

	// Write count needed before a bus bit rises, in input words
	function automatic logic [CW-1:0] rise_count(input logic [7:0] off, input logic both,
			input in_width_type iw, input out_width_type ow);
		logic [CW-1:0] base;
		base = {{(CW-8){1'b0}}, off};
		if (ow != OUT_X36) begin
			rise_count = base + CW'(1);
		end else begin
			base = base + (both ? CW'(2) : CW'(1));
			if (iw == IN_X18) begin
				rise_count = base << 1;
			end else if (iw == IN_X9) begin
				rise_count = base << 2;
			end else begin
				rise_count = base;
			end
		end
	endfunction

	// Straps caught by a clock while master reset is low
	strap_type strap_q, strap_d;
	logic mrs_q, mrs_d;
	always_comb begin
		strap_d = strap_q;
		if (!master_reset_n) begin
			strap_d = '{flag_mode: flag_mode_sel, packet_mode: packet_mode_sel,
				offset_sel: default_offset_sel, leader: chain_leader_sel};
		end
		mrs_d = master_reset_n;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			strap_q <= '0;
			mrs_q <= 1'b0;
		end else begin
			strap_q <= strap_d;
			mrs_q <= mrs_d;
		end
	end
	wire logic [7:0] ae_off = strap_q.offset_sel ? `AE_OFFSET_HIGH : `AE_OFFSET_LOW;
	wire logic release_edge = master_reset_n && !mrs_q;

	// Per-queue levels, packet counts and flag pipelines
	logic [CW-1:0] lvl_q [QUEUES];
	logic [CW-1:0] lvl_d [QUEUES];
	logic [7:0] pkt_q [QUEUES];
	logic [7:0] pkt_d [QUEUES];
	logic [QUEUES-1:0] open_q, open_d, both_q, both_d;
	logic [QUEUES-1:0] ae_bus_q, ae_bus_d, ae_rd1_q, ae_rd1_d;
	logic [QUEUES-1:0] pr_bus_q, pr_bus_d, pr_st1_q, pr_st1_d;
	logic [QUEUES-1:0] sw_hold_q, sw_hold_d;

	genvar g;
	generate
		for (g = 0; g < QUEUES; g++) begin : g_q
			wire logic wr_hit = wr_en && wr_queue == QA_W'(g);
			wire logic rd_hit = rd_en && rd_queue == QA_W'(g);
			wire logic end_mark = wr_hit && wr_data[`END_MARK_BIT];
			wire logic rd_start = rd_hit && rd_data[`START_MARK_BIT];
			logic [CW-1:0] thr;
			always_comb begin
				thr = rise_count(ae_off, both_q[g], in_width, out_width);
				lvl_d[g] = lvl_q[g];
				if (wr_hit && !rd_hit) begin
					lvl_d[g] = lvl_q[g] + CW'(1);
				end else if (rd_hit && !wr_hit && lvl_q[g] != '0) begin
					lvl_d[g] = lvl_q[g] - CW'(1);
				end
				// Read queue presence at the first write sets the boundary
				both_d[g] = both_q[g];
				if (wr_hit && lvl_q[g] == '0) begin
					both_d[g] = rd_queue == QA_W'(g);
				end
				// A start marker opens a packet, the first end marker completes it
				open_d[g] = open_q[g];
				pkt_d[g] = pkt_q[g];
				if (wr_hit && wr_data[`START_MARK_BIT]) begin
					open_d[g] = 1'b1;
				end
				if (end_mark && open_q[g]) begin
					open_d[g] = 1'b0;
					pkt_d[g] = pkt_q[g] + 8'h01;
				end
				if (rd_start && pkt_q[g] != 8'h00 && !(end_mark && open_q[g])) begin
					pkt_d[g] = pkt_q[g] - 8'h01;
				end
				// Reads pass through one stage so the flag falls two clocks later
				ae_rd1_d[g] = lvl_d[g] >= thr;
				ae_bus_d[g] = ae_rd1_q[g];
				if (wr_hit && lvl_d[g] >= thr) begin
					ae_bus_d[g] = 1'b1;
				end
				pr_st1_d[g] = pkt_d[g] == 8'h00;
				pr_bus_d[g] = pr_st1_q[g];
				sw_hold_d[g] = rd_switch;
			end
			always_ff @(posedge ref_clk or negedge rst_n) begin
				if (!rst_n) begin
					lvl_q[g] <= '0;
					pkt_q[g] <= 8'h00;
				end else if (!mrs_q) begin
					lvl_q[g] <= '0;
					pkt_q[g] <= 8'h00;
				end else begin
					lvl_q[g] <= lvl_d[g];
					pkt_q[g] <= pkt_d[g];
				end
			end
		end
	endgenerate

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			open_q <= '0;
			both_q <= '0;
			ae_rd1_q <= '0;
			ae_bus_q <= '0;
			pr_st1_q <= '1;
			pr_bus_q <= '1;
			sw_hold_q <= '0;
		end else begin
			open_q <= open_d;
			both_q <= both_d;
			ae_rd1_q <= ae_rd1_d;
			ae_bus_q <= ae_bus_d;
			pr_st1_q <= pr_st1_d;
			pr_bus_q <= pr_bus_d;
			sw_hold_q <= sw_hold_d;
		end
	end

	// Bus image holds its old value one extra clock when the read queue switches
	logic [QUEUES-1:0] bus_img_q, bus_img_d;
	logic ae_act_q, ae_act_d, pr_act_q, pr_act_d;
	always_comb begin
		bus_img_d = strap_q.packet_mode ? pr_bus_q : ae_bus_q;
		if (sw_hold_q[0]) begin
			bus_img_d = bus_img_q;
		end
		// Taken from the registered bits so the active flags keep the bus timing
		ae_act_d = ae_bus_q[rd_queue];
		pr_act_d = pr_bus_q[rd_queue];
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			bus_img_q <= '0;
			ae_act_q <= 1'b0;
			pr_act_q <= 1'b1;
		end else begin
			bus_img_q <= bus_img_d;
			ae_act_q <= ae_act_d;
			pr_act_q <= pr_act_d;
		end
	end
	assign almost_empty_flag = ae_act_q;
	assign packet_ready_flag = pr_act_q;
	assign ae_status_bus = bus_img_q;
	// Grant comes from the read-side bus owner, so one device drives at a time
	assign ae_status_bus_oe = {QUEUES{flag_bus_grant}};

	// Almost-full bus ownership, direct or polled
	af_state_type af_q, af_d;
	logic own_q, own_d, sel_q, sel_d;
	logic [QUEUES-1:0] af_img_q, af_img_d;
	// Bits above the queue field carry the chip number
	wire logic chip_match = write_queue_addr[4:`CHIP_FIELD_LSB] == chip_number_pins;
	always_comb begin
		af_d = af_q;
		sel_d = sel_q;
		if (af_bus_strobe) begin
			sel_d = chip_match;
		end
		own_d = 1'b0;
		if (!strap_q.flag_mode) begin
			af_d = AF_IDLE;
			own_d = sel_d;
		end else if (release_edge && strap_q.leader) begin
			af_d = AF_SYNC;
			own_d = 1'b1;
		end else if (mrs_q && af_token_in) begin
			af_d = AF_OWN;
			own_d = 1'b1;
		end else begin
			af_d = AF_IDLE;
		end
		if (!master_reset_n) begin
			af_d = AF_IDLE;
			own_d = 1'b0;
			sel_d = 1'b0;
		end
		af_img_d = af_status_in;
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			af_q <= AF_IDLE;
			own_q <= 1'b0;
			sel_q <= 1'b0;
			af_img_q <= '1;
		end else begin
			af_q <= af_d;
			own_q <= own_d;
			sel_q <= sel_d;
			af_img_q <= af_img_d;
		end
	end
	assign af_status_bus = af_img_q;
	assign af_status_bus_oe = {QUEUES{own_q}};
	assign af_sync_pulse = af_q == AF_SYNC;
	assign af_token_out = own_q && strap_q.flag_mode;

	// Read-side flag checks; queue 0 stands for every queue
	offset_pick_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ae_off == (strap_q.offset_sel ? 8'h80 : 8'h08)) else $error("offset wrong");

	lvl_clear_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!mrs_q |=> lvl_q[0] == '0) else $error("level not cleared by master reset");

	// A write in the same clock may hold the bit up, so it is left out
	ae_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ae_rd1_q[0] == 1'b0 && $past(ae_rd1_d[0]) == 1'b0 && !rd_switch && !g_q[0].wr_hit)
		|-> ##1 !ae_bus_q[0]) else $error("bus bit late to fall");

	ae_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(ae_bus_d[0] && !ae_bus_q[0]) |=> ae_bus_q[0]) else $error("bus bit not raised");

	pr_fall_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !mrs_q)
		(g_q[0].end_mark && open_q[0] && pkt_q[0] == 8'h00 && !g_q[0].rd_start)
		|-> ##2 !pr_bus_q[0]) else $error("packet flag not set");

	pr_rise_a: assert property (@(posedge ref_clk) disable iff (!rst_n || !mrs_q)
		(g_q[0].rd_start && pkt_q[0] == 8'h01 && !g_q[0].end_mark)
		|-> ##2 pr_bus_q[0]) else $error("packet flag not cleared");

	// Flag bus checks; the bus image is one clock behind the per-queue bits
	bus_pkt_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(strap_q.packet_mode && !sw_hold_q[0]) |=> ae_status_bus == $past(pr_bus_q))
		else $error("flag bus not showing packet status");

	bus_ae_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!strap_q.packet_mode && !sw_hold_q[0]) |=> ae_status_bus == $past(ae_bus_q))
		else $error("flag bus not showing almost-empty status");

	switch_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sw_hold_q[0] |=> $stable(ae_status_bus)) else $error("flag bus moved on a switch");

	strap_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		master_reset_n |=> $stable(strap_q)) else $error("straps moved after master reset");

	oe_grant_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		ae_status_bus_oe == {QUEUES{flag_bus_grant}}) else $error("flag bus driven without grant");

	// Almost-full bus checks
	direct_sel_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!strap_q.flag_mode && master_reset_n && af_bus_strobe)
		|=> (af_status_bus_oe[0] == $past(chip_match))) else $error("select late");

	direct_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!strap_q.flag_mode && !af_bus_strobe && master_reset_n)
		|=> $stable(af_status_bus_oe)) else $error("ownership moved without strobe");

	sel_miss_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!strap_q.flag_mode && master_reset_n && af_bus_strobe && !chip_match)
		|=> af_status_bus_oe == '0) else $error("bus kept after other chip selected");

	// Image is registered every clock whatever the owner
	af_image_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		1'b1 |=> af_status_bus == $past(af_status_in)) else $error("almost-full image stale");

	mrs_off_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!master_reset_n |=> af_status_bus_oe == '0) else $error("bus driven in master reset");

	sync_once_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		af_sync_pulse |=> !af_sync_pulse) else $error("sync longer than one");

	sync_lead_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		af_sync_pulse |-> (strap_q.leader && af_token_out)) else $error("sync without leader");

	token_own_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		strap_q.flag_mode |-> (af_token_out == af_status_bus_oe[0])) else $error("token");

	token_pass_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(strap_q.flag_mode && mrs_q && af_token_in && master_reset_n)
		|=> af_token_out) else $error("token not taken");

	// No token in and no release edge means no ownership next clock
	token_quiet_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(strap_q.flag_mode && master_reset_n && !af_token_in && !release_edge)
		|=> !af_token_out) else $error("token out without token in");

	direct_sync_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!strap_q.flag_mode |-> !af_sync_pulse) else $error("sync pulse in direct mode");

	release_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		!own_q |-> af_status_bus_oe == '0) else $error("bus driven when idle");

	// Main scenarios
	sync_c: cover property (@(posedge ref_clk) disable iff (!rst_n) af_sync_pulse);
	pr_c: cover property (@(posedge ref_clk) disable iff (!rst_n) !packet_ready_flag);
	ae_c: cover property (@(posedge ref_clk) disable iff (!rst_n) $rose(ae_status_bus[0]));
	direct_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		!strap_q.flag_mode && af_status_bus_oe[0]);
	token_c: cover property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(af_token_in) ##1 af_token_out);
endmodule

/* tb/af_chain_model.sv */
// Model of the other chained devices that pass the almost-full token back
`timescale 1ns/1ps
module af_chain_model #(
	parameter int OTHERS = 2
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Token ring
	input wire logic token_from_dut,
	output logic token_to_dut
);
	logic [OTHERS-1:0] hold_q;
	logic [OTHERS-1:0] hold_d;
	// Each other device owns the bus for one cycle, then hands on
	always_comb begin
		hold_d = {hold_q[OTHERS-2:0], token_from_dut};
	end
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			hold_q <= '0;
		end else begin
			hold_q <= hold_d;
		end
	end
	// Last device feeds the first one again
	assign token_to_dut = hold_q[OTHERS-1];
endmodule

/* tb/queue_flag_status_tb.sv */
// Self-checking testbench for the queue flag status block
`timescale 1ns/1ps
module queue_flag_status_tb;
	import qflag_pkg::*;
	logic ref_clk = 0, rst_n = 0, master_reset_n = 0;
	logic default_offset_sel = 0, packet_mode_sel = 0, flag_mode_sel = 0, chain_leader_sel = 0;
	logic [2:0] chip_number_pins = 3'h5;
	in_width_type in_width = IN_X36;
	out_width_type out_width = OUT_X36;
	logic wr_en = 0, rd_en = 0, rd_switch = 0, af_bus_strobe = 0, flag_bus_grant = 1;
	logic [1:0] wr_queue = 2'h0, rd_queue = 2'h0;
	logic [35:0] wr_data = 36'h0, rd_data = 36'h0;
	logic [4:0] write_queue_addr = 5'h00;
	logic [3:0] af_status_in = 4'hA;
	logic af_token_in, almost_empty_flag, packet_ready_flag, af_sync_pulse, af_token_out;
	logic [3:0] ae_status_bus, ae_status_bus_oe, af_status_bus, af_status_bus_oe;
	int n_mismatch = 0, total_checks = 0;

	queue_flag_status u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .master_reset_n(master_reset_n),
		.default_offset_sel(default_offset_sel), .packet_mode_sel(packet_mode_sel),
		.flag_mode_sel(flag_mode_sel), .chain_leader_sel(chain_leader_sel),
		.chip_number_pins(chip_number_pins), .in_width(in_width), .out_width(out_width),
		.wr_en(wr_en), .wr_queue(wr_queue), .wr_data(wr_data),
		.write_queue_addr(write_queue_addr), .af_bus_strobe(af_bus_strobe),
		.af_status_in(af_status_in), .af_token_in(af_token_in), .rd_en(rd_en),
		.rd_queue(rd_queue), .rd_switch(rd_switch), .rd_data(rd_data),
		.flag_bus_grant(flag_bus_grant), .almost_empty_flag(almost_empty_flag),
		.packet_ready_flag(packet_ready_flag), .ae_status_bus(ae_status_bus),
		.ae_status_bus_oe(ae_status_bus_oe), .af_status_bus(af_status_bus),
		.af_status_bus_oe(af_status_bus_oe), .af_sync_pulse(af_sync_pulse),
		.af_token_out(af_token_out));
	af_chain_model #(.OTHERS(2)) u_chain (.ref_clk(ref_clk), .rst_n(rst_n),
		.token_from_dut(af_token_out), .token_to_dut(af_token_in));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// Inputs change just after an edge, outputs are read there once settled
	task automatic tick(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic mreset(input logic offs, input logic pkt, input logic fm, input logic lead);
		master_reset_n <= 0;
		default_offset_sel <= offs;
		packet_mode_sel <= pkt;
		flag_mode_sel <= fm;
		chain_leader_sel <= lead;
		tick(3);
		master_reset_n <= 1;
	endtask

	// Fill queue 2 with only the write port on it, then read it back to the boundary
	task automatic almost_empty_test(input logic offs);
		int n;
		n = offs ? 128 : 8;
		mreset(offs, 0, 0, 0);
		tick(1);
		rd_queue <= 2'h1;
		wr_queue <= 2'h2;
		wr_en <= 1;
		tick(n);
		wr_en <= 0;
		tick(2);
		check("ae bit at offset", ae_status_bus[2], 0);
		check("bus enable", ae_status_bus_oe, 4'hF);
		wr_en <= 1;
		tick(1);
		wr_en <= 0;
		tick(1);
		check("ae bit after n+1 writes", ae_status_bus[2], 1);
		rd_queue <= 2'h2;
		tick(2);
		rd_en <= 1;
		tick(1);
		rd_en <= 0;
		tick(1);
		check("ae bit one edge after read", ae_status_bus[2], 1);
		tick(1);
		check("ae bit two edges after read", ae_status_bus[2], 0);
		check("active ae flag", almost_empty_flag, 0);
	endtask

	// Queue 3 on both ports: x18 input doubles the count, narrow output ignores both
	task automatic width_test();
		mreset(0, 0, 0, 0);
		in_width <= IN_X18;
		tick(1);
		rd_queue <= 2'h3;
		wr_queue <= 2'h3;
		wr_en <= 1;
		tick(19);
		wr_en <= 0;
		tick(2);
		check("x18 ae bit before boundary", ae_status_bus[3], 0);
		wr_en <= 1;
		tick(1);
		wr_en <= 0;
		tick(1);
		check("x18 ae bit at twice offset+2", ae_status_bus[3], 1);
		rd_switch <= 1;
		tick(1);
		rd_switch <= 0;
		tick(2);
		check("ae bit held over switch", ae_status_bus[3], 1);
		mreset(0, 0, 0, 0);
		in_width <= IN_X36;
		out_width <= OUT_X9;
		tick(1);
		wr_en <= 1;
		tick(8);
		wr_en <= 0;
		tick(2);
		check("x9 out ae bit before boundary", ae_status_bus[3], 0);
		wr_en <= 1;
		tick(1);
		wr_en <= 0;
		tick(1);
		check("x9 out ae bit at offset+1", ae_status_bus[3], 1);
		out_width <= OUT_X36;
	endtask

	task automatic packet_test();
		mreset(0, 1, 0, 0);
		tick(1);
		wr_queue <= 2'h0;
		rd_queue <= 2'h0;
		wr_en <= 1;
		wr_data <= 36'h400000000;
		tick(1);
		wr_data <= 36'h800000000;
		tick(1);
		wr_en <= 0;
		wr_data <= 36'h0;
		tick(1);
		check("ready flag one edge after end", packet_ready_flag, 1);
		tick(1);
		check("ready flag two edges after end", packet_ready_flag, 0);
		check("ready bus bit", ae_status_bus[0], 0);
		rd_en <= 1;
		rd_data <= 36'h400000000;
		tick(1);
		rd_en <= 0;
		rd_data <= 36'h0;
		tick(1);
		check("ready flag one edge after read", packet_ready_flag, 0);
		tick(1);
		check("ready flag cleared", packet_ready_flag, 1);
		check("ready bus bit cleared", ae_status_bus[0], 1);
	endtask

	// Matching strobe takes the bus, another device's address gives it up
	task automatic direct_test();
		mreset(0, 0, 0, 0);
		tick(1);
		// No write queue selection on a bus select cycle
		write_queue_addr <= {3'h5, 2'h3};
		af_bus_strobe <= 1;
		tick(1);
		af_bus_strobe <= 0;
		tick(1);
		check("direct own enable", af_status_bus_oe, 4'hF);
		check("direct bus image", af_status_bus, 4'hA);
		tick(2);
		check("enable holds", af_status_bus_oe, 4'hF);
		write_queue_addr <= {3'h2, 2'h0};
		af_bus_strobe <= 1;
		tick(1);
		af_bus_strobe <= 0;
		tick(1);
		check("direct released", af_status_bus_oe, 4'h0);
	endtask

	task automatic polled_test();
		mreset(0, 0, 1, 1);
		tick(1);
		check("leader sync", af_sync_pulse, 1);
		check("leader token", af_token_out, 1);
		check("leader enable", af_status_bus_oe, 4'hF);
		tick(1);
		check("sync one cycle", af_sync_pulse, 0);
		check("token one cycle", af_token_out, 0);
		check("polled released", af_status_bus_oe, 4'h0);
		tick(2);
		check("token returns", af_token_out, 1);
	endtask

	initial begin
		#(20000 * 5);
		n_mismatch++;
		wrap_up();
	end

	initial begin
		repeat (10) @(posedge ref_clk);
		rst_n <= 1;
		tick(1);
		check("reset ae flag", almost_empty_flag, 0);
		check("reset ready flag", packet_ready_flag, 1);
		check("reset af enable", af_status_bus_oe, 4'h0);
		almost_empty_test(0);
		almost_empty_test(1);
		width_test();
		packet_test();
		direct_test();
		polled_test();
		wrap_up();
	end
endmodule
